// ### bench/independent_window_watchdog_tb_top.sv
// self-checking testbench for the independent window watchdog
`timescale 1ns/1ps
module independent_window_watchdog_tb_top;
    // ----------------------------------------------------------
    // stimulus and observation
    // ----------------------------------------------------------
    logic        mclk_in             = 1'b0;
    logic        rstn_in             = 1'b0;
    logic        wb_cyc_in           = 1'b0;
    logic        wb_stb_in           = 1'b0;
    logic        wb_we_in            = 1'b0;
    logic [7:0]  wb_adr_in           = 8'h00;
    logic [3:0]  wb_sel_in           = 4'hF;
    logic [31:0] wb_dat_in           = 32'h0;
    logic [31:0] wb_dat_out;
    logic        wb_ack_out;
    logic        rc_clk_in           = 1'b0;
    logic        dbg_halt_in         = 1'b0;
    logic        debug_freeze_bit_in = 1'b0;
    logic        hw_autostart_in     = 1'b0;
    logic        sys_reset_out;
    int          bad_count           = 0;
    int          comparisons         = 0;
    int          rst_seen            = 0;
    int          rc_div              = 0;
    int          n;
    logic [31:0] rd;
    logic [31:0] c;

    always #12.5 mclk_in = ~mclk_in;

    // rc pin: 5 main cycles per half period, above the sampling minimum
    always @(posedge mclk_in)
    begin
        rc_div <= (rc_div == 4) ? 0 : rc_div + 1;
        if (rc_div == 4)
            rc_clk_in <= ~rc_clk_in;
    end

    // count reset request pulses
    always @(posedge mclk_in)
        if (sys_reset_out === 1'b1)
            rst_seen <= rst_seen + 1;

    independent_window_watchdog DUT (
        .mclk_in             (mclk_in),
        .rstn_in             (rstn_in),
        .wb_cyc_in           (wb_cyc_in),
        .wb_stb_in           (wb_stb_in),
        .wb_we_in            (wb_we_in),
        .wb_adr_in           (wb_adr_in),
        .wb_sel_in           (wb_sel_in),
        .wb_dat_in           (wb_dat_in),
        .wb_dat_out          (wb_dat_out),
        .wb_ack_out          (wb_ack_out),
        .rc_clk_in           (rc_clk_in),
        .dbg_halt_in         (dbg_halt_in),
        .debug_freeze_bit_in (debug_freeze_bit_in),
        .hw_autostart_in     (hw_autostart_in),
        .sys_reset_out       (sys_reset_out)
    );

    // ----------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // one classic cycle; ack and data taken at the same edge
    task automatic xfer(input logic [7:0] a, input logic we,
                        input logic [31:0] d, input logic [3:0] s);
        int k;
        k = 0;
        @(posedge mclk_in);
        wb_cyc_in <= 1'b1;
        wb_stb_in <= 1'b1;
        wb_we_in  <= we;
        wb_adr_in <= a;
        wb_sel_in <= s;
        wb_dat_in <= d;
        // no cycle limit here: only the bench watchdog ends a stuck wait
        do
        begin
            @(posedge mclk_in);
            k++;
        end
        while (wb_ack_out !== 1'b1);
        rd = wb_dat_out;
        chk({31'h0, wb_ack_out}, 32'h1, "bus ack");
        chk(k, 32'h2, "ack latency");
        wb_cyc_in <= 1'b0;
        wb_stb_in <= 1'b0;
        wb_we_in  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d, 4'hF);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                        input string what);
        xfer(a, 1'b0, 32'h0, 4'hF);
        chk(rd, e, what);
    endtask

    task automatic idle(input int k);
        repeat (k) @(posedge mclk_in);
    endtask

    task automatic do_reset(input logic strap);
        rstn_in         <= 1'b0;
        hw_autostart_in <= strap;
        idle(10);
        rstn_in         <= 1'b1;
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ----------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------
    task automatic t_reset_values;
        rchk(wdog_pkg::ADR_CMD, 32'h0, "cmd reads zero");
        rchk(wdog_pkg::ADR_DIV, 32'h0, "divider reset");
        rchk(wdog_pkg::ADR_RELOAD, 32'hFFF, "reload reset");
        rchk(wdog_pkg::ADR_WIN, 32'hFFF, "window reset");
        rchk(wdog_pkg::ADR_STAT, 32'h0, "status reset");
        rchk(wdog_pkg::ADR_CORE, 32'hFFF, "core idle");
        wr(8'h20, 32'h1234);
        rchk(8'h20, 32'h0, "unmapped read");
        $display("done: reset values");
    endtask

    task automatic t_count;
        wr(wdog_pkg::ADR_RELOAD, 32'h5);
        rchk(wdog_pkg::ADR_RELOAD, 32'hFFF, "locked write");
        wr(wdog_pkg::ADR_CMD, 32'h5555);
        wr(wdog_pkg::ADR_RELOAD, 32'h5);
        rchk(wdog_pkg::ADR_STAT, 32'h2, "reload pending");
        idle(40);
        rchk(wdog_pkg::ADR_STAT, 32'h0, "reload settled");
        wr(wdog_pkg::ADR_CMD, 32'hAAAA);
        idle(30);
        rchk(wdog_pkg::ADR_CORE, 32'h5, "reload loads");
        n = rst_seen;
        wr(wdog_pkg::ADR_CMD, 32'hCCCC);
        idle(30);
        rchk(wdog_pkg::ADR_CORE, 32'h10005, "started");
        idle(90);
        chk(rst_seen, n, "early reset");
        idle(150);
        chk(rst_seen, n + 1, "zero reset");
        $display("done: count to zero");
    endtask

    task automatic t_freeze;
        dbg_halt_in         <= 1'b1;
        debug_freeze_bit_in <= 1'b1;
        idle(20);
        xfer(wdog_pkg::ADR_CORE, 1'b0, 32'h0, 4'hF);
        c = rd;
        idle(100);
        rchk(wdog_pkg::ADR_CORE, c, "frozen");
        debug_freeze_bit_in <= 1'b0;
        idle(60);
        xfer(wdog_pkg::ADR_CORE, 1'b0, 32'h0, 4'hF);
        chk({31'h0, rd !== c}, 32'h1, "runs in halt");
        dbg_halt_in <= 1'b0;
        $display("done: debug freeze");
    endtask

    task automatic t_window;
        wr(wdog_pkg::ADR_CMD, 32'h5555);
        wr(wdog_pkg::ADR_WIN, 32'h2);
        rchk(wdog_pkg::ADR_STAT, 32'h4, "window pending");
        idle(40);
        rchk(wdog_pkg::ADR_STAT, 32'h0, "window settled");
        rchk(wdog_pkg::ADR_CORE, 32'h10005, "window reloads");
        n = rst_seen;
        wr(wdog_pkg::ADR_CMD, 32'hAAAA);
        idle(30);
        chk(rst_seen, n + 1, "early reload reset");
        rd = 32'h0;
        for (int i = 0; i < 100 && rd[11:0] != 12'h2; i++)
            xfer(wdog_pkg::ADR_CORE, 1'b0, 32'h0, 4'hF);
        chk(rd & 32'hFFF, 32'h2, "inside window");
        n = rst_seen;
        wr(wdog_pkg::ADR_CMD, 32'hAAAA);
        idle(40);
        chk(rst_seen, n, "reload in window");
        wr(wdog_pkg::ADR_CMD, 32'h1234);
        wr(wdog_pkg::ADR_WIN, 32'hFFF);
        rchk(wdog_pkg::ADR_WIN, 32'h2, "relocked");
        wr(wdog_pkg::ADR_CMD, 32'h5555);
        xfer(wdog_pkg::ADR_WIN, 1'b1, 32'hFFF, 4'h1);
        rchk(wdog_pkg::ADR_WIN, 32'h2, "byte lane");
        $display("done: window");
    endtask

    task automatic t_divider;
        wr(wdog_pkg::ADR_WIN, 32'hFFF);
        wr(wdog_pkg::ADR_DIV, 32'h7);
        rchk(wdog_pkg::ADR_STAT, 32'h5, "div pending");
        idle(40);
        rchk(wdog_pkg::ADR_DIV, 32'h7, "div value");
        wr(wdog_pkg::ADR_CMD, 32'hAAAA);
        idle(30);
        rchk(wdog_pkg::ADR_CORE, 32'h10005, "slow reload");
        idle(1000);
        rchk(wdog_pkg::ADR_CORE, 32'h10005, "divide 256");
        $display("done: divider");
    endtask

    task automatic t_autostart;
        do_reset(1'b1);
        idle(40);
        xfer(wdog_pkg::ADR_CORE, 1'b0, 32'h0, 4'hF);
        chk(rd & 32'h10000, 32'h10000, "auto start");
        $display("done: auto start");
    endtask

    // ----------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------
    initial
    begin
        do_reset(1'b0);
        t_reset_values();
        t_count();
        t_freeze();
        t_window();
        t_divider();
        t_autostart();
        tally_and_finish();
    end

    // runs take about 2000 cycles; ten times that means a hang
    initial
    begin
        idle(20000);
        bad_count++;
        $display("[ERR] %0t timeout", $time);
        tally_and_finish();
    end
endmodule

// ### shared/wdog_core_if.sv
// carrier between the register side and the counting core
`timescale 1ns/1ps
interface wdog_core_if #(parameter int CNT_W = 12);
    logic                 tick;
    logic                 start;
    logic                 reload;
    logic                 cfg_load;
    logic                 wnd_chg;
    logic [2:0]           div_code;
    logic [CNT_W-1:0]     reload_count;
    logic [CNT_W-1:0]     win_limit;
    logic [CNT_W-1:0]     cnt;
    logic                 running;
    logic                 rst_pulse;

    modport main (output tick, start, reload, cfg_load, wnd_chg,
                  output div_code, reload_count, win_limit,
                  input  cnt, running, rst_pulse);
    modport core (input  tick, start, reload, cfg_load, wnd_chg,
                  input  div_code, reload_count, win_limit,
                  output cnt, running, rst_pulse);
endinterface

// ### shared/wdog_pkg.sv
// shared constants for the independent window watchdog
package wdog_pkg;

    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int CNT_W     = 12;
    localparam int PRE_W     = 8;
    localparam int DIV_W     = 3;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADR_CMD    = 8'h00;
    localparam logic [7:0] ADR_DIV    = 8'h04;
    localparam logic [7:0] ADR_RELOAD = 8'h08;
    localparam logic [7:0] ADR_STAT   = 8'h0C;
    localparam logic [7:0] ADR_WIN    = 8'h10;
    localparam logic [7:0] ADR_CORE   = 8'h14;

    // ------------------------------------------------------------
    // command keys
    // ------------------------------------------------------------
    localparam logic [15:0] KEY_UNLOCK = 16'h5555;
    localparam logic [15:0] KEY_START  = 16'hCCCC;
    localparam logic [15:0] KEY_RELOAD = 16'hAAAA;

    // ------------------------------------------------------------
    // field positions and values after reset
    // ------------------------------------------------------------
    localparam int STAT_DIV_BIT    = 0;
    localparam int STAT_RELOAD_BIT = 1;
    localparam int STAT_WIN_BIT    = 2;
    localparam int CORE_RUN_BIT    = 16;
    localparam logic [2:0]  RST_DIV    = 3'h0;
    localparam logic [11:0] RST_RELOAD = 12'hFFF;
    localparam logic [11:0] RST_WIN    = 12'hFFF;

    // ------------------------------------------------------------
    // divider and crossing counts
    // ------------------------------------------------------------
    localparam logic [2:0] DIV_MAX_CODE = 3'h6;
    localparam logic [1:0] PEND_TICKS   = 2'h2;

endpackage

// ### verilog/independent_window_watchdog.sv
// wishbone register front end and crossing logic of the watchdog
//
// Register access over Wishbone is this design's own decision.
`timescale 1ns/1ps
module independent_window_watchdog #(
    parameter int CNT_W = wdog_pkg::CNT_W
) (
    // clock and reset
    input  wire logic         mclk_in,
    input  wire logic         rstn_in,
    // wishbone slave
    input  wire logic         wb_cyc_in,
    input  wire logic         wb_stb_in,
    input  wire logic         wb_we_in,
    input  wire logic [7:0]   wb_adr_in,
    input  wire logic [3:0]   wb_sel_in,
    input  wire logic [31:0]  wb_dat_in,
    output logic      [31:0]  wb_dat_out,
    output logic              wb_ack_out,
    // low speed rc clock, sampled as a plain pin
    input  wire logic         rc_clk_in,
    // debug and option straps
    input  wire logic         dbg_halt_in,
    input  wire logic         debug_freeze_bit_in,
    input  wire logic         hw_autostart_in,
    // system reset request
    output logic              sys_reset_out
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic                 rc_s1;
        logic                 rc_s2;
        logic                 rc_s3;
        logic                 ack;
        logic [31:0]          dat;
        logic                 unlocked;
        logic [2:0]           div_code;
        logic [CNT_W-1:0]     reload_count;
        logic [CNT_W-1:0]     win_limit;
        logic [2:0]           pend;
        logic [1:0]           age;
        logic                 start_req;
        logic                 reload_req;
        logic                 boot;
    } front_t;

    front_t s_r;
    front_t s_nxt;

    logic        frozen;
    logic        tick;
    logic        req;
    logic        wr;
    logic        half;
    logic [15:0] key;
    logic        cmd_wr;
    logic        cfg_ok;
    logic        cfg_load;
    logic [31:0] rd_word;

    wdog_core_if #(.CNT_W(CNT_W)) core_if ();

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    // freeze only while halted with the freeze bit set
    assign frozen = dbg_halt_in & debug_freeze_bit_in;
    // one step per rc rising edge; mclk must far outrun the rc clock
    assign tick   = s_r.rc_s2 & ~s_r.rc_s3 & ~frozen;
    assign req    = wb_cyc_in & wb_stb_in & ~s_r.ack;
    assign wr     = req & wb_we_in;
    // half-word or word on the low lanes; byte writes do nothing
    assign half   = (wb_sel_in[1:0] == 2'b11);
    assign key    = wb_dat_in[15:0];
    assign cmd_wr = wr & half & (wb_adr_in == wdog_pkg::ADR_CMD);
    assign cfg_ok = wr & half & s_r.unlocked;
    // values reach the core when the crossing delay has run out
    assign cfg_load = tick & (|s_r.pend)
                      & (s_r.age == wdog_pkg::PEND_TICKS - 2'h1);

    // read data; command register reads as zero
    always_comb
    begin
        unique case (wb_adr_in)
            wdog_pkg::ADR_DIV:    rd_word = 32'(s_r.div_code);
            wdog_pkg::ADR_RELOAD: rd_word = 32'(s_r.reload_count);
            wdog_pkg::ADR_STAT:   rd_word = 32'(s_r.pend);
            wdog_pkg::ADR_WIN:    rd_word = 32'(s_r.win_limit);
            wdog_pkg::ADR_CORE:
            begin
                rd_word = 32'(core_if.cnt);
                rd_word[wdog_pkg::CORE_RUN_BIT] = core_if.running;
            end
            default:              rd_word = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        s_nxt       = s_r;
        // rc pin synchroniser and edge history
        s_nxt.rc_s1 = rc_clk_in;
        s_nxt.rc_s2 = s_r.rc_s1;
        s_nxt.rc_s3 = s_r.rc_s2;
        // single-cycle ack, dropped the cycle after
        s_nxt.ack   = req;
        s_nxt.dat   = (req & ~wb_we_in) ? rd_word : 32'h0000_0000;

        // commands handed over on the tick, then cleared
        if (tick)
        begin
            s_nxt.start_req  = 1'b0;
            s_nxt.reload_req = 1'b0;
        end

        // crossing delay: flags drop after the set number of ticks
        if (tick && (|s_r.pend))
        begin
            s_nxt.age = s_r.age + 2'h1;
            if (cfg_load)
            begin
                s_nxt.pend = 3'h0;
                s_nxt.age  = 2'h0;
            end
        end

        // strap caught once, just after reset release
        if (!s_r.boot)
        begin
            s_nxt.boot = 1'b1;
            if (hw_autostart_in)
                s_nxt.start_req = 1'b1;
        end

        // commands; a new request beats the hand-over clear
        if (cmd_wr)
        begin
            s_nxt.unlocked = (key == wdog_pkg::KEY_UNLOCK);
            if (key == wdog_pkg::KEY_START)
                s_nxt.start_req = 1'b1;
            if (key == wdog_pkg::KEY_RELOAD)
                s_nxt.reload_req = 1'b1;
        end

        // protected writes; flag set wins over the crossing clear
        if (cfg_ok && wb_adr_in == wdog_pkg::ADR_DIV)
        begin
            s_nxt.div_code = wb_dat_in[2:0];
            s_nxt.pend[wdog_pkg::STAT_DIV_BIT] = 1'b1;
            s_nxt.age = 2'h0;
        end
        if (cfg_ok && wb_adr_in == wdog_pkg::ADR_RELOAD)
        begin
            s_nxt.reload_count = wb_dat_in[CNT_W-1:0];
            s_nxt.pend[wdog_pkg::STAT_RELOAD_BIT] = 1'b1;
            s_nxt.age = 2'h0;
        end
        if (cfg_ok && wb_adr_in == wdog_pkg::ADR_WIN)
        begin
            s_nxt.win_limit = wb_dat_in[CNT_W-1:0];
            s_nxt.pend[wdog_pkg::STAT_WIN_BIT] = 1'b1;
            s_nxt.age = 2'h0;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            s_r              <= '0;
            s_r.div_code     <= wdog_pkg::RST_DIV;
            s_r.reload_count <= wdog_pkg::RST_RELOAD;
            s_r.win_limit    <= wdog_pkg::RST_WIN;
        end
        else
            s_r <= s_nxt;
    end

    // ------------------------------------------------------------
    // core hookup
    // ------------------------------------------------------------
    assign core_if.tick         = tick;
    assign core_if.start        = s_r.start_req;
    assign core_if.reload       = s_r.reload_req;
    assign core_if.cfg_load     = cfg_load;
    // window change forces a reload as it lands
    assign core_if.wnd_chg      = cfg_load & s_r.pend[wdog_pkg::STAT_WIN_BIT];
    assign core_if.div_code     = s_r.div_code;
    assign core_if.reload_count = s_r.reload_count;
    assign core_if.win_limit    = s_r.win_limit;

    wdog_core #(.CNT_W(CNT_W)) u_core (
        .clk_in  (mclk_in),
        .rstn_in (rstn_in),
        .cfg_bus (core_if.core)
    );

    // bus and reset outputs
    assign wb_ack_out    = s_r.ack;
    assign wb_dat_out    = s_r.dat;
    assign sys_reset_out = core_if.rst_pulse;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rstn_in);

    AST_START_LATCH: assert property (
        cmd_wr && key == wdog_pkg::KEY_START |=> s_r.start_req)
        else $error("start key not latched");

    AST_START_RUN: assert property (
        tick && s_r.start_req |=> core_if.running)
        else $error("start request did not enable counting");

    AST_ZERO_RESET: assert property (
        tick && core_if.running && core_if.cnt == '0 |=> sys_reset_out)
        else $error("no reset at zero count");

    AST_RELOAD_LOAD: assert property (
        tick && s_r.reload_req && s_r.pend == 3'h0
        |=> core_if.cnt == $past(s_r.reload_count))
        else $error("reload did not load counter");

    AST_WINDOW_RESET: assert property (
        tick && s_r.reload_req && s_r.pend == 3'h0 && core_if.running
        && core_if.cnt != '0 && core_if.cnt > s_r.win_limit
        |=> sys_reset_out)
        else $error("early reload did not reset");

    AST_NO_FALSE_RESET: assert property (
        sys_reset_out |-> $past(tick) && $past(core_if.running))
        else $error("reset without a running tick");

    AST_WIN_RELOAD: assert property (
        core_if.wnd_chg |=> core_if.cnt == $past(s_r.reload_count))
        else $error("window change did not reload");

    AST_LOCKED: assert property (
        wr && !s_r.unlocked |=> $stable(s_r.reload_count)
        && $stable(s_r.win_limit) && $stable(s_r.div_code))
        else $error("locked register changed");

    AST_RELOCK: assert property (
        cmd_wr && key != wdog_pkg::KEY_UNLOCK |=> !s_r.unlocked)
        else $error("protection not restored");

    AST_PEND_HOLD: assert property (
        cfg_ok && wb_adr_in == wdog_pkg::ADR_RELOAD
        |=> s_r.pend[wdog_pkg::STAT_RELOAD_BIT] && !cfg_load)
        else $error("reload update flag not set");

    AST_FREEZE: assert property (
        frozen ##1 frozen |-> $stable(core_if.cnt))
        else $error("counter moved while frozen");

    AST_PULSE: assert property (
        sys_reset_out |=> !sys_reset_out)
        else $error("reset request longer than one cycle");

    AST_ACK: assert property (
        req |=> wb_ack_out ##1 !wb_ack_out)
        else $error("ack not a single cycle");

    COV_START: cover property (tick && s_r.start_req);
    COV_ZERO: cover property (core_if.running && sys_reset_out);
    COV_WINDOW: cover property (core_if.wnd_chg);
    COV_UNLOCK_WRITE: cover property (cfg_ok);

endmodule

// ### verilog/wdog_core.sv
// prescaler and down counter of the watchdog, stepped on rc ticks
`timescale 1ns/1ps
module wdog_core #(
    parameter int CNT_W = 12
) (
    // clock and reset
    input  wire logic  clk_in,
    input  wire logic  rstn_in,
    // register side
    wdog_core_if.core  cfg_bus
);

    typedef struct packed {
        logic                          en;
        logic                          rst;
        logic [wdog_pkg::PRE_W-1:0]    pre;
        logic [CNT_W-1:0]              cnt;
        logic [2:0]                    div_code;
        logic [CNT_W-1:0]              reload_count;
        logic [CNT_W-1:0]              win_limit;
    } core_t;

    core_t s_r;
    core_t s_nxt;
    logic [CNT_W-1:0] eff_reload;
    logic [CNT_W-1:0] eff_win;

    // terminal prescaler count: (4 << code) - 1, codes above 6 saturate
    function automatic logic [7:0] div_limit(input logic [2:0] code);
        logic [2:0]  cap;
        logic [15:0] full;
        cap  = (code > wdog_pkg::DIV_MAX_CODE) ? wdog_pkg::DIV_MAX_CODE
                                               : code;
        full = (16'h0004 << cap) - 16'h0001;
        return full[7:0];
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        s_nxt      = s_r;
        s_nxt.rst  = 1'b0;
        // freshly crossed reload and window values win on the tick they arrive; the divider code applies from the next tick
        eff_reload = cfg_bus.cfg_load ? cfg_bus.reload_count
                                      : s_r.reload_count;
        eff_win    = cfg_bus.cfg_load ? cfg_bus.win_limit : s_r.win_limit;
        if (cfg_bus.tick)
        begin
            if (cfg_bus.cfg_load)
            begin
                s_nxt.div_code     = cfg_bus.div_code;
                s_nxt.reload_count = cfg_bus.reload_count;
                s_nxt.win_limit    = cfg_bus.win_limit;
            end
            if (cfg_bus.start)
                s_nxt.en = 1'b1;
            if (s_r.en && s_r.cnt == '0)
            begin
                s_nxt.rst = 1'b1;
                s_nxt.cnt = eff_reload;
                s_nxt.pre = '0;
            end
            else if (cfg_bus.reload && s_r.en && s_r.cnt > eff_win)
            begin
                s_nxt.rst = 1'b1;
                s_nxt.cnt = eff_reload;
                s_nxt.pre = '0;
            end
            else if (cfg_bus.reload || cfg_bus.wnd_chg)
            begin
                s_nxt.cnt = eff_reload;
                s_nxt.pre = '0;
            end
            else if (s_r.en)
            begin
                if (s_r.pre == div_limit(s_r.div_code))
                begin
                    s_nxt.pre = '0;
                    s_nxt.cnt = s_r.cnt - 1'b1;
                end
                else
                    s_nxt.pre = s_r.pre + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            s_r              <= '0;
            s_r.cnt          <= wdog_pkg::RST_RELOAD;
            s_r.div_code     <= wdog_pkg::RST_DIV;
            s_r.reload_count <= wdog_pkg::RST_RELOAD;
            s_r.win_limit    <= wdog_pkg::RST_WIN;
        end
        else
            s_r <= s_nxt;
    end

    // outputs straight from flops; reset request is a one-cycle pulse
    assign cfg_bus.cnt       = s_r.cnt;
    assign cfg_bus.running   = s_r.en;
    assign cfg_bus.rst_pulse = s_r.rst;

endmodule
